/* core/charger_smbus_control_regs.sv */
// Behaviour
// - answer only target address 0x12; never start a bus transfer.
// - registers reached by read-word and write-word, low data byte first.
// - decode exactly seven command codes, one per register.
// - options register holds watchdog period field, including disable.
// - enabled watchdog with no voltage/current write in period suspends charge.
// - after watchdog suspend, a voltage or current write resumes charging.
// - out of reset internal logic controls reverse-block switch turn-on.
// - out of reset internal logic controls the battery switch.
// - adapter removed stops charge, sleeps; battery connected only if enabled.
// - override bit hands both switches to their drive bits.
// - open-drain adapter-good output flags adapter sense above 2 V.
// - sense must stay high 250 ms before switches and good output enable.
// - clearing the adapter-delay bit skips the stability delay.
// - adapter and reverse-block switches driven by the gate-drive output.
// - options bits 9 and 10 select converter switching frequency.
// - illegal charge voltage write clears register and stops charging.
// - charge current outside 128..16320 mA clears register, stops charge.
// - input current outside 128..16256 mA clears register, stops charge.
`timescale 1ns/1ps
module charger_smbus_control_regs #(
  parameter int          TICK_CYCLES = charger_pkg::TICK_CYCLES,
  parameter int          DEGLITCH_MS = charger_pkg::DEGLITCH_MS,
  parameter int          WD_SHORT_MS = charger_pkg::WD_SHORT_MS,
  parameter int          WD_MID_MS   = charger_pkg::WD_MID_MS,
  parameter int          WD_LONG_MS  = charger_pkg::WD_LONG_MS,
  // identity values are arbitrary
  parameter logic [15:0] MAKER_ID    = charger_pkg::MAKER_ID,
  parameter logic [15:0] PART_ID     = charger_pkg::PART_ID
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        smbClock,
  input  wire logic        smbDataIn,
  output logic             smbDataOut,
  output logic             smbDataOe,
  input  wire logic        adapterSenseIn,
  input  wire logic [10:0] faultIn,
  output logic             adapterGoodOut,
  output logic             adapterGoodOe,
  output logic             adapterGateDrive,
  output logic             batterySwitch,
  output logic             chargeEnable,
  output logic [1:0]       switchFreqSel
);

  // ==========================================================
  // helpers
  function automatic logic cmdValid(input logic [7:0] c);
    case (c)
      charger_pkg::CMD_OPT, charger_pkg::CMD_STAT,
      charger_pkg::CMD_CURR, charger_pkg::CMD_VOLT,
      charger_pkg::CMD_INP, charger_pkg::CMD_MAKER,
      charger_pkg::CMD_PART: cmdValid = 1'b1;
      default:               cmdValid = 1'b0;
    endcase
  endfunction : cmdValid

  function automatic logic voltOk(input logic [15:0] v);
    voltOk = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (v >= charger_pkg::VOLT_MIN[i] && v <= charger_pkg::VOLT_MAX[i])
        voltOk = 1'b1;
    end
  endfunction : voltOk

  function automatic logic [16:0] wdLast(input logic [1:0] sel);
    case (sel)
      2'h1:    wdLast = 17'(WD_SHORT_MS - 1);
      2'h2:    wdLast = 17'(WD_MID_MS - 1);
      default: wdLast = 17'(WD_LONG_MS - 1);
    endcase
  endfunction : wdLast

  // ==========================================================
  // state
  charger_pkg::state_type s_r;
  charger_pkg::state_type s_nxt;

  logic        sclRise, sclFall, busStart, busStop, msTick;
  logic        commit, timerWrite, currOk, inpOk, voltGood, wdOn;
  logic [7:0]  full;
  logic [15:0] word, readWord;

  // only the second and third sync stages feed the decoders
  assign sclRise  = s_r.sclB & ~s_r.sclC;
  assign sclFall  = ~s_r.sclB & s_r.sclC;
  assign busStart = s_r.sclB & s_r.sclC & s_r.sdaC & ~s_r.sdaB;
  assign busStop  = s_r.sclB & s_r.sclC & ~s_r.sdaC & s_r.sdaB;
  assign msTick   = s_r.tick == 18'(TICK_CYCLES - 1);
  assign full     = {s_r.shift[6:0], s_r.sdaB};
  assign word     = {full, s_r.loByte};
  assign commit   = s_r.bus == charger_pkg::BUS_RX && sclRise
                  && s_r.bitCnt == 3'h7 && s_r.phase == 2'h3;
  // range checks see only the value field: reserved bits are ignored
  assign currOk   = (word & charger_pkg::CURR_MASK) >= charger_pkg::CURR_MIN
                  && (word & charger_pkg::CURR_MASK)
                     <= charger_pkg::CURR_MAX;
  assign inpOk    = (word & charger_pkg::INP_MASK) >= charger_pkg::INP_MIN
                  && (word & charger_pkg::INP_MASK)
                     <= charger_pkg::INP_MAX;
  assign voltGood = voltOk(word & charger_pkg::VOLT_MASK);
  assign timerWrite = commit
    && ((s_r.cmd == charger_pkg::CMD_CURR && currOk)
     || (s_r.cmd == charger_pkg::CMD_VOLT && voltGood));
  assign wdOn = s_r.opt[charger_pkg::OPT_WD_HI:charger_pkg::OPT_WD_LO]
              != 2'h0;

  always_comb begin
    case (s_r.cmd)
      charger_pkg::CMD_OPT:   readWord = s_r.opt;
      charger_pkg::CMD_STAT:  readWord = {5'h00, s_r.fltB};
      charger_pkg::CMD_CURR:  readWord = s_r.curr;
      charger_pkg::CMD_VOLT:  readWord = s_r.volt;
      charger_pkg::CMD_INP:   readWord = s_r.inp;
      charger_pkg::CMD_MAKER: readWord = MAKER_ID;
      charger_pkg::CMD_PART:  readWord = PART_ID;
      default:                readWord = 16'h0000;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt      = s_r;
    s_nxt.sclA = smbClock;
    s_nxt.sclB = s_r.sclA;
    s_nxt.sclC = s_r.sclB;
    s_nxt.sdaA = smbDataIn;
    s_nxt.sdaB = s_r.sdaA;
    s_nxt.sdaC = s_r.sdaB;
    s_nxt.senA = adapterSenseIn;
    s_nxt.senB = s_r.senA;
    s_nxt.fltA = faultIn;
    s_nxt.fltB = s_r.fltA;
    s_nxt.tick = msTick ? 18'h00000 : s_r.tick + 18'h00001;

    // target-only engine: it drives data low, never the clock
    case (s_r.bus)
      charger_pkg::BUS_RX: begin
        if (sclRise) begin
          s_nxt.shift  = full;
          s_nxt.bitCnt = s_r.bitCnt + 3'h1;
          if (s_r.bitCnt == 3'h7) begin
            s_nxt.bus = charger_pkg::BUS_ACK;
            case (s_r.phase)
              2'h0: begin
                s_nxt.rw     = full[0];
                s_nxt.txWord = readWord;
                if (full[7:1] != charger_pkg::TARGET_ADDR)
                  s_nxt.bus = charger_pkg::BUS_IDLE;
              end
              2'h1: begin
                s_nxt.cmd = full;
                if (!cmdValid(full))
                  s_nxt.bus = charger_pkg::BUS_IDLE;
              end
              2'h2:    s_nxt.loByte = full;
              default: s_nxt.loByte = s_r.loByte;
            endcase
          end
        end
      end
      charger_pkg::BUS_ACK: begin
        if (sclFall && !s_r.ackOn) begin
          s_nxt.sdaDrive = 1'b1;
          s_nxt.ackOn    = 1'b1;
        end else if (sclFall) begin
          s_nxt.ackOn    = 1'b0;
          s_nxt.sdaDrive = 1'b0;
          s_nxt.bitCnt   = 3'h0;
          if (s_r.rw && s_r.phase == 2'h0) begin
            s_nxt.bus      = charger_pkg::BUS_TX;
            s_nxt.shift    = s_r.txWord[7:0];
            s_nxt.sdaDrive = ~s_r.txWord[7];
            s_nxt.txHi     = 1'b0;
          end else if (s_r.phase == 2'h3) begin
            s_nxt.bus = charger_pkg::BUS_IDLE;
          end else begin
            s_nxt.bus   = charger_pkg::BUS_RX;
            s_nxt.phase = s_r.phase + 2'h1;
          end
        end
      end
      charger_pkg::BUS_TX: begin
        if (sclFall && s_r.bitCnt == 3'h7) begin
          s_nxt.sdaDrive = 1'b0;
          s_nxt.bus      = charger_pkg::BUS_TXACK;
        end else if (sclFall) begin
          s_nxt.bitCnt   = s_r.bitCnt + 3'h1;
          s_nxt.shift    = {s_r.shift[6:0], 1'b0};
          s_nxt.sdaDrive = ~s_r.shift[6];
        end
      end
      charger_pkg::BUS_TXACK: begin
        if (sclRise)
          s_nxt.ackOn = ~s_r.sdaB;
        if (sclFall && s_r.ackOn && !s_r.txHi) begin
          s_nxt.bus      = charger_pkg::BUS_TX;
          s_nxt.txHi     = 1'b1;
          s_nxt.bitCnt   = 3'h0;
          s_nxt.shift    = s_r.txWord[15:8];
          s_nxt.sdaDrive = ~s_r.txWord[15];
          s_nxt.ackOn    = 1'b0;
        end else if (sclFall) begin
          s_nxt.bus   = charger_pkg::BUS_IDLE;
          s_nxt.ackOn = 1'b0;
        end
      end
      default: s_nxt.bus = charger_pkg::BUS_IDLE;
    endcase
    if (busStart) begin
      s_nxt.bus      = charger_pkg::BUS_RX;
      s_nxt.bitCnt   = 3'h0;
      s_nxt.phase    = 2'h0;
      s_nxt.ackOn    = 1'b0;
      s_nxt.sdaDrive = 1'b0;
    end else if (busStop) begin
      s_nxt.bus      = charger_pkg::BUS_IDLE;
      s_nxt.sdaDrive = 1'b0;
    end

    // register writes; status and identity are not writable
    if (commit) begin
      case (s_r.cmd)
        charger_pkg::CMD_OPT:  s_nxt.opt = word;
        charger_pkg::CMD_CURR: s_nxt.curr = currOk
          ? (word & charger_pkg::CURR_MASK) : 16'h0000;
        charger_pkg::CMD_VOLT: s_nxt.volt = voltGood
          ? (word & charger_pkg::VOLT_MASK) : 16'h0000;
        charger_pkg::CMD_INP:  s_nxt.inp = inpOk
          ? (word & charger_pkg::INP_MASK) : 16'h0000;
        default:               s_nxt.opt = s_r.opt;
      endcase
    end

    // ========================================================
    // watchdog
    if (timerWrite) begin
      s_nxt.wdMs      = 17'h00000;
      s_nxt.wdExpired = 1'b0;
    end else if (!wdOn) begin
      s_nxt.wdMs      = 17'h00000;
      s_nxt.wdExpired = 1'b0;
    end else if (msTick && !s_r.wdExpired) begin
      if (s_r.wdMs >= wdLast(s_r.opt[14:13]))
        s_nxt.wdExpired = 1'b1;
      else
        s_nxt.wdMs = s_r.wdMs + 17'h00001;
    end

    // ========================================================
    // adapter detection and selectors
    if (!s_r.senB) begin
      s_nxt.good = 1'b0;
      s_nxt.dgMs = 8'h00;
    end else if (!s_r.opt[charger_pkg::OPT_AD]) begin
      s_nxt.good = 1'b1;
    end else if (!s_r.good && msTick) begin
      if (s_r.dgMs == 8'(DEGLITCH_MS - 1))
        s_nxt.good = 1'b1;
      else
        s_nxt.dgMs = s_r.dgMs + 8'h01;
    end
    // good drops without delay so removal stops charge at once
    if (s_r.opt[charger_pkg::OPT_OVR]) begin
      s_nxt.gate  = s_r.opt[charger_pkg::OPT_ADAPTER_SELECTOR_DRIVE];
      s_nxt.batSw = s_r.opt[charger_pkg::OPT_BED];
    end else begin
      s_nxt.gate  = s_r.good;
      s_nxt.batSw = ~s_r.good & s_r.opt[charger_pkg::OPT_BSE];
    end
    s_nxt.chg = s_r.good && !s_r.wdExpired && s_r.curr != 16'h0000
      && s_r.volt != 16'h0000 && s_r.inp != 16'h0000;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_r      <= '0;
      s_r.sclA <= 1'b1;
      s_r.sclB <= 1'b1;
      s_r.sclC <= 1'b1;
      s_r.sdaA <= 1'b1;
      s_r.sdaB <= 1'b1;
      s_r.sdaC <= 1'b1;
      s_r.bus  <= charger_pkg::BUS_IDLE;
      s_r.opt  <= charger_pkg::OPT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign smbDataOut       = 1'b0;
  assign smbDataOe        = s_r.sdaDrive;
  assign adapterGoodOut   = 1'b0;
  assign adapterGoodOe    = ~s_r.good;
  assign adapterGateDrive = s_r.gate;
  assign batterySwitch    = s_r.batSw;
  assign chargeEnable     = s_r.chg;
  assign switchFreqSel    = s_r.opt[10:9];

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_idle_silent: assert property (
    s_r.bus == charger_pkg::BUS_IDLE |-> !smbDataOe)
    else $error("data driven while idle");
  chk_addr_match: assert property (
    $rose(smbDataOe) && s_r.phase == 2'h0 && s_r.bus == charger_pkg::BUS_ACK
    |-> s_r.shift[7:1] == charger_pkg::TARGET_ADDR)
    else $error("ack to foreign address");
  chk_cmd_decode: assert property (
    s_r.bus == charger_pkg::BUS_ACK && s_r.phase == 2'h1 |-> cmdValid(s_r.cmd))
    else $error("unknown command acked");
  chk_wd_suspend: assert property (
    s_r.wdExpired |=> !chargeEnable)
    else $error("charge on after watchdog expiry");
  chk_wd_resume: assert property (
    s_r.wdExpired && timerWrite |=> !s_r.wdExpired)
    else $error("watchdog not cleared by write");
  chk_wd_restart: assert property (
    timerWrite |=> s_r.wdMs == 17'h00000)
    else $error("watchdog not restarted");
  chk_dgl_time: assert property (
    $rose(s_r.good) && $past(s_r.opt[15])
    |-> $past(s_r.dgMs) == 8'(DEGLITCH_MS - 1) && $past(msTick))
    else $error("adapter good before deglitch");
  chk_skip_delay: assert property (
    s_r.senB && !s_r.opt[15] |=> s_r.good ##1 adapterGateDrive || s_r.opt[5])
    else $error("delay not skipped");
  chk_override: assert property (
    s_r.opt[5] |=> adapterGateDrive == $past(s_r.opt[3])
    && batterySwitch == $past(s_r.opt[4]))
    else $error("override not followed");
  chk_sleep_batt: assert property (
    !s_r.opt[5] && !s_r.good |=> batterySwitch == $past(s_r.opt[12])
    && !chargeEnable)
    else $error("sleep battery switch wrong");
  chk_curr_range: assert property (
    commit && s_r.cmd == charger_pkg::CMD_CURR && !currOk
    |=> s_r.curr == 16'h0000 ##1 !chargeEnable)
    else $error("illegal current kept");
  chk_good_pin: assert property (
    !s_r.senB |=> adapterGoodOe)
    else $error("adapter good without sense");

  cov_write: cover property (commit);
  cov_read: cover property (s_r.bus == charger_pkg::BUS_TX && s_r.txHi);
  cov_wd_expire: cover property ($rose(s_r.wdExpired));
  cov_adapter: cover property ($rose(s_r.good) && s_r.opt[15]);

endmodule : charger_smbus_control_regs

/* core/charger_pkg.sv */
package charger_pkg;

  // ==========================================================
  // bus addressing and command codes
  localparam logic [6:0] TARGET_ADDR = 7'h12;
  localparam logic [7:0] CMD_OPT     = 8'h12;
  localparam logic [7:0] CMD_STAT    = 8'h13;
  localparam logic [7:0] CMD_CURR    = 8'h14;
  localparam logic [7:0] CMD_VOLT    = 8'h15;
  localparam logic [7:0] CMD_INP     = 8'h3f;
  localparam logic [7:0] CMD_MAKER   = 8'hfe;
  localparam logic [7:0] CMD_PART    = 8'hff;

  // ==========================================================
  // options register fields
  localparam int OPT_AD    = 15;
  localparam int OPT_WD_HI = 14;
  localparam int OPT_WD_LO = 13;
  localparam int OPT_BSE   = 12;
  localparam int OPT_FQ_HI = 10;
  localparam int OPT_FQ_LO = 9;
  localparam int OPT_OVR   = 5;
  localparam int OPT_BED   = 4;
  localparam int OPT_ADAPTER_SELECTOR_DRIVE  = 3;
  localparam logic [15:0] OPT_RESET = 16'hf101;

  // ==========================================================
  // value fields and legal ranges
  localparam logic [15:0] CURR_MASK = 16'h3fc0;
  localparam logic [15:0] CURR_MIN  = 16'h0080;
  localparam logic [15:0] CURR_MAX  = 16'h3fc0;
  localparam logic [15:0] INP_MASK  = 16'h3f80;
  localparam logic [15:0] INP_MIN   = 16'h0080;
  localparam logic [15:0] INP_MAX   = 16'h3f80;
  localparam logic [15:0] VOLT_MASK = 16'h7ffe;
  localparam logic [15:0] VOLT_MIN [6] = '{16'h1f40, 16'h2ee0,
    16'h3e80, 16'h1a90, 16'h27d8, 16'h3520};
  localparam logic [15:0] VOLT_MAX [6] = '{16'h2338, 16'h34d4,
    16'h4670, 16'h1e88, 16'h2dcc, 16'h3d10};
  localparam int FAULT_BITS = 11;
  localparam logic [15:0] MAKER_ID = 16'h0001;
  localparam logic [15:0] PART_ID  = 16'h0000;

  // ==========================================================
  // timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int TICK_TIME_NS    = 1000000;
  localparam int TICK_CYCLES     = TICK_TIME_NS / CLOCK_PERIOD_NS;
  localparam int DEGLITCH_MS     = 250;
  localparam int WD_SHORT_MS     = 40000;
  localparam int WD_MID_MS       = 80000;
  localparam int WD_LONG_MS      = 120000;

  // ==========================================================
  // types
  typedef enum logic [4:0] {
    BUS_IDLE  = 5'b00001,
    BUS_RX    = 5'b00010,
    BUS_ACK   = 5'b00100,
    BUS_TX    = 5'b01000,
    BUS_TXACK = 5'b10000
  } bus_state_type;

  typedef struct packed {
    logic                  sclA, sclB, sclC;
    logic                  sdaA, sdaB, sdaC;
    logic                  senA, senB;
    logic [FAULT_BITS-1:0] fltA, fltB;
    bus_state_type         bus;
    logic [2:0]            bitCnt;
    logic [1:0]            phase;
    logic                  rw, ackOn, txHi, sdaDrive;
    logic [7:0]            shift, cmd, loByte;
    logic [15:0]           txWord, opt, curr, volt, inp;
    logic [17:0]           tick;
    logic [16:0]           wdMs;
    logic                  wdExpired;
    logic [7:0]            dgMs;
    logic                  good, gate, batSw, chg;
  } state_type;

endpackage : charger_pkg

/* verification/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model #(
  parameter int PH = 64
) (
  input  wire logic devDataOe,
  output logic      smbClock,
  output logic      smbData
);
  // ==========================================================
  // wire and idle levels
  // pull-up wins unless a party pulls low; each scl phase spans PH ns,
  // above six core clocks, so the synchronisers never miss an edge
  logic hostRel;
  assign smbData = hostRel & ~devDataOe;
  initial begin
    smbClock = 1'b1;
    hostRel  = 1'b1;
  end

  // ==========================================================
  // bit, byte and frame tasks
  task automatic bitIo(input logic b, output logic seen);
    #(PH/2) hostRel = b;
    #(PH/2) smbClock = 1'b1;
    #(PH/2) seen = smbData;
    #(PH/2) smbClock = 1'b0;
  endtask : bitIo

  // msb first; v of all ones releases the line to receive
  task automatic byteIo(input logic [7:0] v, input logic ackIn,
                        output logic [7:0] got, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(v[i], s);
      got[i] = s;
    end
    bitIo(ackIn, s);
    acked = ~s;
  endtask : byteIo

  task automatic startC();
    #(PH/2) hostRel = 1'b1;
    #(PH/2) smbClock = 1'b1;
    #(PH/2) hostRel = 1'b0;
    #(PH/2) smbClock = 1'b0;
  endtask : startC

  task automatic stopC();
    #(PH/2) hostRel = 1'b0;
    #(PH/2) smbClock = 1'b1;
    #(PH/2) hostRel = 1'b1;
    #(PH/2);
  endtask : stopC

  task automatic writeWord(input logic [6:0] adr, input logic [7:0] cmd,
                           input logic [15:0] val, output logic [3:0] acks);
    logic [7:0] g;
    startC();
    byteIo({adr, 1'b0}, 1'b1, g, acks[3]);
    byteIo(cmd, 1'b1, g, acks[2]);
    byteIo(val[7:0], 1'b1, g, acks[1]);
    byteIo(val[15:8], 1'b1, g, acks[0]);
    stopC();
  endtask : writeWord

  task automatic readWord(input logic [6:0] adr, input logic [7:0] cmd,
                          output logic [15:0] val, output logic [2:0] acks);
    logic [7:0] g;
    logic       a;
    startC();
    byteIo({adr, 1'b0}, 1'b1, g, acks[2]);
    byteIo(cmd, 1'b1, g, acks[1]);
    startC();
    byteIo({adr, 1'b1}, 1'b1, g, acks[0]);
    byteIo(8'hff, 1'b0, val[7:0], a);
    byteIo(8'hff, 1'b1, val[15:8], a);
    stopC();
  endtask : readWord
endmodule : smbus_host_model

/* verification/tb_charger_smbus_control_regs.sv */
`timescale 1ns/1ps
module tb_charger_smbus_control_regs;
  // ==========================================================
  // shortened counts: 10-clock tick, so deglitch is 80 clocks
  localparam int          TICK  = 10;
  localparam int          DEG   = 8;
  localparam int          WDS   = 200;
  localparam logic [15:0] MAKER = 16'h0a5c; // arbitrary value
  localparam logic [15:0] PART  = 16'h05ca; // arbitrary value
  localparam logic [7:0]  cmds [7] = '{8'h12, 8'h13, 8'h14, 8'h15,
    8'h3f, 8'hfe, 8'hff};
  localparam logic [15:0] resv [7] = '{16'hf101, 16'h0, 16'h0, 16'h0,
    16'h0, MAKER, PART};
  localparam logic [15:0] bad [3] = '{16'h0040, 16'h2500, 16'h0000};
  logic        clock, reset, smbClock, smbData, smbDataOe;
  logic        adapterSenseIn, adapterGoodOe, adapterGateDrive;
  logic        batterySwitch, chargeEnable;
  logic [10:0] faultIn;
  logic [1:0]  switchFreqSel;
  logic [15:0] rd, v;
  logic [3:0]  wa;
  logic [2:0]  ra;
  int          n_mismatch, compares;

  charger_smbus_control_regs #(.TICK_CYCLES(TICK), .DEGLITCH_MS(DEG),
    .WD_SHORT_MS(WDS), .WD_MID_MS(300), .WD_LONG_MS(400),
    .MAKER_ID(MAKER), .PART_ID(PART)) i_charger_smbus_control_regs (
    .clock(clock), .reset(reset), .smbClock(smbClock),
    .smbDataIn(smbData), .smbDataOut(), .smbDataOe(smbDataOe),
    .adapterSenseIn(adapterSenseIn), .faultIn(faultIn),
    .adapterGoodOut(), .adapterGoodOe(adapterGoodOe),
    .adapterGateDrive(adapterGateDrive), .batterySwitch(batterySwitch),
    .chargeEnable(chargeEnable), .switchFreqSel(switchFreqSel));
  smbus_host_model #(.PH(32)) i_smbus_host_model (
    .devDataOe(smbDataOe), .smbClock(smbClock), .smbData(smbData));

  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic s, input logic e);
    check({15'h0, s}, {15'h0, e});
  endtask : chk1

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_smbus_host_model.writeWord(charger_pkg::TARGET_ADDR, c, d, wa);
    check({12'h0, wa}, 16'h000f);
    cyc(1);
  endtask : wr

  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    i_smbus_host_model.readWord(charger_pkg::TARGET_ADDR, c, rd, ra);
    check({13'h0, ra}, 16'h0007);
    check(rd, e);
    cyc(1);
  endtask : rdc

  // reserved bits dropped, out-of-range values read back as zero
  function automatic logic [15:0] expOf(input logic [7:0] c,
                                        input logic [15:0] d);
    logic [15:0] r;
    r = 16'h0000;
    if (c == charger_pkg::CMD_CURR) r = d & charger_pkg::CURR_MASK;
    if (c == charger_pkg::CMD_INP) r = d & charger_pkg::INP_MASK;
    for (int i = 0; i < 6 && c == charger_pkg::CMD_VOLT; i++) begin
      if ((d & charger_pkg::VOLT_MASK) >= charger_pkg::VOLT_MIN[i] &&
          (d & charger_pkg::VOLT_MASK) <= charger_pkg::VOLT_MAX[i]) begin
        r = d & charger_pkg::VOLT_MASK;
      end
    end
    return (r >= charger_pkg::CURR_MIN) ? r : 16'h0000;
  endfunction : expOf

  function automatic logic [15:0] newVal(input logic [7:0] c);
    int r;
    r = $urandom_range(5, 0);
    if (c == charger_pkg::CMD_CURR) begin
      return 16'($urandom_range(255, 2) << 6) | 16'($urandom & 32'hc03f);
    end
    if (c == charger_pkg::CMD_INP) begin
      return 16'($urandom_range(127, 1) << 7) | 16'($urandom & 32'hc07f);
    end
    return charger_pkg::VOLT_MIN[r] + 16'(2 * $urandom_range(0, 
      (charger_pkg::VOLT_MAX[r] - charger_pkg::VOLT_MIN[r]) / 2))
      | 16'($urandom & 32'h8001);
  endfunction : newVal

  task automatic loadAll();
    for (int i = 2; i < 5; i++) begin
      v = newVal(cmds[i]);
      wr(cmds[i], v);
      rdc(cmds[i], expOf(cmds[i], v));
    end
  endtask : loadAll

  // ==========================================================
  // clock, watchdog and test sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #450us;
    n_mismatch++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    adapterSenseIn = 1'b0;
    faultIn = 11'h000;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(32'h8f8f908d));
    cyc(4);
    reset = 1'b0;
    cyc(3);
    check({13'h0, adapterGateDrive, chargeEnable, adapterGoodOe}, 16'h1);
    check({13'h0, switchFreqSel, batterySwitch}, 16'h1);
    faultIn = 11'($urandom);
    cyc(4);
    for (int i = 0; i < 7; i++) begin
      rdc(cmds[i], i == 1 ? {5'h0, faultIn} : resv[i]);
    end
    for (int i = 1; i < 7; i += (i == 1) ? 4 : 1) begin
      wr(cmds[i], 16'($urandom));
      rdc(cmds[i], i == 1 ? {5'h0, faultIn} : resv[i]);
    end
    i_smbus_host_model.writeWord(7'h12 ^ 7'($urandom_range(127, 1)),
      charger_pkg::CMD_OPT, 16'h0000, wa);
    cyc(1);
    check({12'h0, wa}, 16'h0000);
    i_smbus_host_model.writeWord(charger_pkg::TARGET_ADDR, 8'h16, 16'h0, wa);
    cyc(1);
    check({12'h0, wa}, 16'h0008);
    repeat (3) begin
      v = 16'($urandom) & 16'h9fdf | 16'h8000;
      wr(charger_pkg::CMD_OPT, v);
      rdc(charger_pkg::CMD_OPT, v);
      check({14'h0, switchFreqSel}, {14'h0, v[10:9]});
    end
    // a short glitch must restart the stability count
    wr(charger_pkg::CMD_OPT, 16'h9000);
    adapterSenseIn = 1'b1;
    cyc(20);
    adapterSenseIn = 1'b0;
    cyc(10);
    adapterSenseIn = 1'b1;
    cyc(60);
    chk1(adapterGoodOe, 1'b1);
    for (int k = 0; k < 60 && adapterGoodOe !== 1'b0; k++) cyc(1);
    chk1(adapterGoodOe, 1'b0);
    cyc(2);
    check({14'h0, adapterGateDrive, batterySwitch}, 16'h2);
    loadAll();
    chk1(chargeEnable, 1'b1);
    adapterSenseIn = 1'b0;
    for (int k = 0; k < 20 && adapterGoodOe !== 1'b1; k++) cyc(1);
    cyc(2);
    check({13'h0, adapterGateDrive, chargeEnable, batterySwitch}, 16'h1);
    wr(charger_pkg::CMD_OPT, 16'h8000);
    chk1(batterySwitch, 1'b0);
    wr(charger_pkg::CMD_OPT, 16'h1000);
    adapterSenseIn = 1'b1;
    cyc(6);
    chk1(adapterGoodOe, 1'b0);
    for (int b = 0; b < 4; b++) begin
      wr(charger_pkg::CMD_OPT, 16'h1020 | 16'(b << 3));
      check({14'h0, batterySwitch, adapterGateDrive}, 16'(b));
    end
    wr(charger_pkg::CMD_OPT, 16'h1000);
    for (int i = 0; i < 3; i++) begin
      loadAll();
      chk1(chargeEnable, 1'b1);
      wr(cmds[i + 2], bad[i]);
      rdc(cmds[i + 2], expOf(cmds[i + 2], bad[i]));
      chk1(chargeEnable, 1'b0);
    end
    loadAll();
    wr(charger_pkg::CMD_OPT, 16'h3000);
    wr(charger_pkg::CMD_CURR, 16'h0100);
    cyc(1700);
    chk1(chargeEnable, 1'b1);
    for (int k = 0; k < 600 && chargeEnable !== 1'b0; k++) cyc(1);
    chk1(chargeEnable, 1'b0);
    wr(charger_pkg::CMD_VOLT, 16'h1f40);
    chk1(chargeEnable, 1'b1);
    cyc(1000);
    wr(charger_pkg::CMD_CURR, 16'h0100);
    cyc(1700);
    chk1(chargeEnable, 1'b1);
    wr(charger_pkg::CMD_OPT, 16'h1000);
    cyc(2500);
    chk1(chargeEnable, 1'b1);
    conclude();
  end
endmodule : tb_charger_smbus_control_regs
